// file: testbench/host_model.sv
// Host model driving chip select and the store and recall pins
`default_nettype none

module host_model #(
    parameter int PWR_WAIT    = 8,
    parameter int RECALL_HOLD = 100,
    parameter int STORE_HOLD  = 40
)
(
    // Clock
    input  wire logic mclk_in,
    // Pins towards the device
    output var logic  store_b_out,
    output var logic  recall_b_out,
    output var logic  chip_select_out
);
    timeunit 1ns;
    timeprecision 1ps;

    int recall_cnt = 0;
    int store_cnt  = 0;

    initial
    begin
        store_b_out = 1'b1;
        recall_b_out = 1'b1;
        chip_select_out = 1'b1;
    end

    // Release the store and recall pins once their minimum low time has run out
    always @(negedge mclk_in)
    begin
        if (recall_cnt > 0)
        begin
            recall_cnt <= recall_cnt - 1;
            if (recall_cnt == 1)
                recall_b_out <= 1'b1;
        end
        if (store_cnt > 0)
        begin
            store_cnt <= store_cnt - 1;
            if (store_cnt == 1)
                store_b_out <= 1'b1;
        end
    end

    // Supply settling wait, shortened
    task automatic power_wait();
        repeat (PWR_WAIT) @(negedge mclk_in);
    endtask

    task automatic settle();
        while (recall_cnt != 0 || store_cnt != 0)
            @(negedge mclk_in);
    endtask

    task automatic start_recall();
        settle();
        recall_b_out <= 1'b0;
        recall_cnt <= RECALL_HOLD;
    endtask

    task automatic start_store();
        settle();
        store_b_out <= 1'b0;
        store_cnt <= STORE_HOLD;
    endtask

    task automatic set_select(input logic v);
        chip_select_out <= v;
    endtask
endmodule

`default_nettype wire

// file: testbench/tb.sv
// Testbench for the store and recall control block
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int STORE_LEN  = 40;
    localparam int RECALL_LEN = 20;

    logic        mclk = 1'b0;
    logic        rst_b = 1'b1;
    logic        store_b, recall_b, cs;
    logic        busy = 1'b0, sw_recall = 1'b0, sw_store = 1'b0, we = 1'b0, wd = 1'b0;
    logic        drive = 1'b1, dbit = 1'b1, ram_wr = 1'b0;
    logic [3:0]  ram_addr = 4'h3;
    logic [15:0] ram_wdata = 16'h0000;
    logic [15:0] rdata;
    logic        sdo, oe, recalling, storing, done, we_lat, pr_lat;
    int          fail_count = 0;
    int          compares = 0;
    int          cyc = 0;

    always #2.5 mclk = ~mclk;

    host_model host_model_inst (.mclk_in(mclk), .store_b_out(store_b), .recall_b_out(recall_b),
        .chip_select_out(cs));

    nv_store_recall_control #(.STORE_CYCLES(STORE_LEN), .RECALL_CYCLES(RECALL_LEN))
        nv_store_recall_control_inst (.mclk_in(mclk), .rst_b_in(rst_b), .store_b_in(store_b),
        .recall_b_in(recall_b), .chip_select_in(cs), .instr_busy_in(busy),
        .sw_recall_cmd_in(sw_recall), .sw_store_cmd_in(sw_store), .write_enable_cmd_in(we),
        .write_disable_cmd_in(wd), .data_drive_in(drive), .data_bit_in(dbit),
        .ram_wr_in(ram_wr), .ram_addr_in(ram_addr), .ram_wdata_in(ram_wdata),
        .ram_rdata_out(rdata), .serial_data_out(sdo), .serial_data_oe_out(oe),
        .recalling_out(recalling), .storing_out(storing), .xfer_done_out(done),
        .write_enable_latch_out(we_lat), .prev_recall_latch_out(pr_lat));

    task automatic wrap_up();
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle strobe, entered and left at a falling edge
    task automatic pulse(ref logic s);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask

    // Counts cycles until the done pulse and checks the length
    task automatic xfer_len(input int exp_len);
        int n;
        n = 0;
        while (done !== 1'b1 && n < 2000)
        begin
            @(negedge mclk);
            n++;
        end
        chk(16'(n), 16'(exp_len));
    endtask

    task automatic ram_word(input logic [3:0] a, input logic [15:0] d);
        ram_addr = a;
        ram_wdata = d;
        pulse(ram_wr);
    endtask

    task automatic t_locked();
        chk({14'h0, we_lat, pr_lat}, 16'h0000);
        host_model_inst.start_store();
        @(negedge mclk);
        chk({15'h0, storing}, 16'h0000);
        pulse(sw_recall);
        chk({15'h0, recalling}, 16'h0000);
        host_model_inst.settle();
        pulse(sw_store);
        chk({15'h0, storing}, 16'h0000);
    endtask

    task automatic t_hw_recall();
        busy = 1'b1;
        host_model_inst.start_recall();
        @(negedge mclk);
        chk({15'h0, recalling}, 16'h0000);
        busy = 1'b0;
        host_model_inst.start_recall();
        @(negedge mclk);
        chk({14'h0, recalling, oe}, 16'h0002);
        xfer_len(RECALL_LEN);
        chk({15'h0, pr_lat}, 16'h0001);
    endtask

    task automatic t_store();
        ram_word(4'h3, 16'hA5A5);
        pulse(we);
        chk({15'h0, we_lat}, 16'h0001);
        host_model_inst.set_select(1'b0);
        host_model_inst.start_store();
        @(negedge mclk);
        chk({15'h0, storing}, 16'h0000);
        host_model_inst.set_select(1'b1);
        host_model_inst.start_store();
        @(negedge mclk);
        chk({15'h0, storing}, 16'h0001);
        xfer_len(STORE_LEN);
        host_model_inst.settle();
        pulse(sw_store);
        chk({15'h0, storing}, 16'h0001);
        pulse(sw_recall);
        chk({15'h0, recalling}, 16'h0000);
        xfer_len(STORE_LEN - 1);
        pulse(wd);
        chk({15'h0, we_lat}, 16'h0000);
    endtask

    task automatic t_sw_recall();
        ram_word(4'h3, 16'h0000);
        @(negedge mclk);
        chk(rdata, 16'h0000);
        pulse(sw_recall);
        chk({15'h0, recalling}, 16'h0001);
        xfer_len(RECALL_LEN);
        ram_addr = 4'h3;
        @(negedge mclk);
        @(negedge mclk);
        chk(rdata, 16'hA5A5);
    endtask

    task automatic t_float();
        @(negedge mclk);
        chk({14'h0, oe, sdo}, 16'h0003);
        dbit = 1'b0;
        @(negedge mclk);
        chk({14'h0, oe, sdo}, 16'h0002);
        drive = 1'b0;
        @(negedge mclk);
        chk({15'h0, oe}, 16'h0000);
        drive = 1'b1;
        @(negedge mclk);
        chk({15'h0, oe}, 16'h0001);
        host_model_inst.set_select(1'b0);
        @(negedge mclk);
        @(negedge mclk);
        chk({15'h0, oe}, 16'h0000);
    endtask

    // Reset in mid-run clears both latches and the outputs
    task automatic t_reset();
        pulse(we);
        chk({14'h0, we_lat, pr_lat}, 16'h0003);
        rst_b = 1'b0;
        @(negedge mclk);
        chk({14'h0, we_lat, pr_lat}, 16'h0000);
        chk(rdata, 16'h0000);
        chk({13'h0, recalling, storing, done}, 16'h0000);
        rst_b = 1'b1;
        @(negedge mclk);
        @(negedge mclk);
        chk({14'h0, we_lat, pr_lat}, 16'h0000);
    endtask

    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 6000)
        begin
            fail_count++;
            wrap_up();
        end
    end

    initial
    begin
        #1 rst_b = 1'b0;
        repeat (6) @(negedge mclk);
        rst_b = 1'b1;
        host_model_inst.power_wait();
        t_locked();
        t_hw_recall();
        t_store();
        t_sw_recall();
        t_float();
        t_reset();
        wrap_up();
    end
endmodule

`default_nettype wire

// file: verilog/nv_store_recall_control.sv
// Store and recall control between shadow RAM and nonvolatile array
`default_nettype none

module nv_store_recall_control
    import nv_store_recall_pkg::*;
#(
    parameter int STORE_CYCLES  = STORE_DURATION_CYCLES,
    parameter int RECALL_CYCLES = RECALL_CYCLE_CYCLES
)
(
    // Clock and reset
    input  wire logic              mclk_in,
    input  wire logic              rst_b_in,
    // Host pins
    input  wire logic              store_b_in,
    input  wire logic              recall_b_in,
    input  wire logic              chip_select_in,
    // From serial instruction decoder
    input  wire logic              instr_busy_in,
    input  wire logic              sw_recall_cmd_in,
    input  wire logic              sw_store_cmd_in,
    input  wire logic              write_enable_cmd_in,
    input  wire logic              write_disable_cmd_in,
    input  wire logic              data_drive_in,
    input  wire logic              data_bit_in,
    // Host RAM access
    input  wire logic              ram_wr_in,
    input  wire logic [ADDR_W-1:0] ram_addr_in,
    input  wire logic [WORD_W-1:0] ram_wdata_in,
    output logic      [WORD_W-1:0] ram_rdata_out,
    // Serial data output pin
    output logic                   serial_data_out,
    output logic                   serial_data_oe_out,
    // Status
    output logic                   recalling_out,
    output logic                   storing_out,
    output logic                   xfer_done_out,
    output logic                   write_enable_latch_out,
    output logic                   prev_recall_latch_out
);

    typedef struct packed {
        xfer_state_e      st;
        logic [CNT_W-1:0] cnt;
        logic             we;
        logic             pr;
        logic             store_b_q;
        logic             recall_b_q;
        logic             oe;
        logic             dout;
        logic             done;
        logic             recalling;
        logic             storing;
    } ctrl_s;

    localparam logic [CNT_W-1:0] STORE_LAST  = CNT_W'(STORE_CYCLES - 1);
    localparam logic [CNT_W-1:0] RECALL_LAST = CNT_W'(RECALL_CYCLES - 1);
    localparam logic [CNT_W-1:0] COPY_LAST   = CNT_W'(WORDS);

    ctrl_s r;
    ctrl_s next_r;

    logic              store_fall;
    logic              recall_fall;
    logic              hw_recall;
    logic              sw_recall;
    logic              hw_store;
    logic              sw_store;
    logic              copy_wr;
    logic [ADDR_W-1:0] copy_waddr;
    logic [ADDR_W-1:0] copy_raddr;
    logic              sram_wr;
    logic [ADDR_W-1:0] sram_waddr;
    logic [WORD_W-1:0] sram_wdata;
    logic [ADDR_W-1:0] sram_raddr;
    logic [WORD_W-1:0] sram_rdata;
    logic [WORD_W-1:0] nv_rdata;

    // Request decode
    always_comb
    begin
        store_fall  = r.store_b_q & ~store_b_in;
        recall_fall = r.recall_b_q & ~recall_b_in;
        hw_recall   = recall_fall & store_b_in & ~instr_busy_in;
        sw_recall   = sw_recall_cmd_in & store_b_in & recall_b_in;
        hw_store    = store_fall & recall_b_in & chip_select_in & ~instr_busy_in
                      & r.we & r.pr;
        sw_store    = sw_store_cmd_in & store_b_in & recall_b_in & chip_select_in
                      & r.we & r.pr;
    end

    // Word copy sequencing: read word k, write it one cycle later
    always_comb
    begin
        copy_wr    = (r.st != ST_IDLE) && (r.cnt != '0) && (r.cnt <= COPY_LAST);
        copy_waddr = ADDR_W'(r.cnt - CNT_W'(1));
        copy_raddr = r.cnt[ADDR_W-1:0];
        if (r.st == ST_RECALL)
        begin
            sram_wr    = copy_wr;
            sram_waddr = copy_waddr;
            sram_wdata = nv_rdata;
        end
        else
        begin
            sram_wr    = (r.st == ST_IDLE) & ram_wr_in;
            sram_waddr = ram_addr_in;
            sram_wdata = ram_wdata_in;
        end
        sram_raddr = (r.st == ST_STORE) ? copy_raddr : ram_addr_in;
    end

    // Next state
    always_comb
    begin
        next_r            = r;
        next_r.store_b_q  = store_b_in;
        next_r.recall_b_q = recall_b_in;
        next_r.done       = 1'b0;
        if (write_disable_cmd_in)
        begin
            next_r.we = 1'b0;
        end
        if (write_enable_cmd_in)
        begin
            next_r.we = 1'b1;
        end
        case (r.st)
            ST_IDLE:
            begin
                next_r.cnt = '0;
                if (hw_recall || sw_recall)
                begin
                    next_r.st = ST_RECALL;
                end
                else if (hw_store || sw_store)
                begin
                    next_r.st = ST_STORE;
                end
            end
            ST_RECALL:
            begin
                next_r.cnt = r.cnt + CNT_W'(1);
                if (r.cnt == RECALL_LAST)
                begin
                    next_r.st   = ST_IDLE;
                    next_r.pr   = 1'b1;
                    next_r.done = 1'b1;
                end
            end
            ST_STORE:
            begin
                next_r.cnt = r.cnt + CNT_W'(1);
                if (r.cnt == STORE_LAST)
                begin
                    next_r.st   = ST_IDLE;
                    next_r.done = 1'b1;
                end
            end
            default:
            begin
                next_r.st  = ST_IDLE;
                next_r.cnt = '0;
            end
        endcase
        next_r.recalling = (next_r.st == ST_RECALL);
        next_r.storing   = (next_r.st == ST_STORE);
        // Output floats on deselect, recall pin low, or any transfer
        next_r.oe   = data_drive_in & chip_select_in & recall_b_in
                      & (next_r.st == ST_IDLE);
        next_r.dout = data_bit_in;
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            r            <= '0;
            r.st         <= ST_IDLE;
            r.we         <= WE_LATCH_RST;
            r.pr         <= PR_LATCH_RST;
            r.store_b_q  <= 1'b1;
            r.recall_b_q <= 1'b1;
        end
        else
        begin
            r <= next_r;
        end
    end

    // Shadow RAM
    nv_word_mem #(.DEPTH(WORDS), .WIDTH(WORD_W), .AW(ADDR_W)) u_sram (
        .mclk_in     (mclk_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    (sram_wr),
        .wr_addr_in  (sram_waddr),
        .wr_data_in  (sram_wdata),
        .rd_addr_in  (sram_raddr),
        .rd_data_out (sram_rdata)
    );

    // Nonvolatile array
    nv_word_mem #(.DEPTH(WORDS), .WIDTH(WORD_W), .AW(ADDR_W)) u_nv (
        .mclk_in     (mclk_in),
        .rst_b_in    (rst_b_in),
        .wr_en_in    ((r.st == ST_STORE) & copy_wr),
        .wr_addr_in  (copy_waddr),
        .wr_data_in  (sram_rdata),
        .rd_addr_in  (copy_raddr),
        .rd_data_out (nv_rdata)
    );

    assign ram_rdata_out          = sram_rdata;
    assign serial_data_out        = r.dout;
    assign serial_data_oe_out     = r.oe;
    assign recalling_out          = r.recalling;
    assign storing_out            = r.storing;
    assign xfer_done_out          = r.done;
    assign write_enable_latch_out = r.we;
    assign prev_recall_latch_out  = r.pr;

    // Checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rst_b_in);

    sequence s_hw_recall_req;
        (r.st == ST_IDLE) && recall_fall && store_b_in && !instr_busy_in;
    endsequence
    sequence s_sw_recall_req;
        (r.st == ST_IDLE) && sw_recall_cmd_in && store_b_in && recall_b_in;
    endsequence
    sequence s_recall_run;
        recalling_out && !storing_out;
    endsequence

    property p_hw_recall;
        s_hw_recall_req |=> s_recall_run;
    endproperty
    a_hw_recall: assert property (p_hw_recall) else $error("pin recall not started");

    property p_sw_recall;
        s_sw_recall_req |=> s_recall_run ##1 recalling_out;
    endproperty
    a_sw_recall: assert property (p_sw_recall) else $error("command recall not started");

    property p_store_latches;
        $rose(storing_out) |-> $past(write_enable_latch_out) && $past(prev_recall_latch_out);
    endproperty
    a_store_latches: assert property (p_store_latches) else $error("store without latches");

    property p_pin_idle;
        (r.st == ST_IDLE) && instr_busy_in && !sw_recall_cmd_in && !sw_store_cmd_in
            |=> !recalling_out && !storing_out;
    endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("pin acted on while busy");

    property p_recall_float;
        !recall_b_in |=> !serial_data_oe_out;
    endproperty
    a_recall_float: assert property (p_recall_float) else $error("output driven in recall");

    property p_select_float;
        (!chip_select_in || storing_out) |-> ##[0:1] !serial_data_oe_out;
    endproperty
    a_select_float: assert property (p_select_float) else $error("output not floated");

    property p_store_end;
        storing_out && (r.cnt == STORE_LAST) |=> !storing_out && xfer_done_out;
    endproperty
    a_store_end: assert property (p_store_end) else $error("store did not end on time");

    property p_reset_latches;
        @(posedge mclk_in) disable iff (1'b0)
        !rst_b_in |-> !write_enable_latch_out && !prev_recall_latch_out;
    endproperty
    a_reset_latches: assert property (p_reset_latches) else $error("latch set in reset");

    property p_store_blocked;
        (r.st == ST_IDLE) && (!recall_b_in || !chip_select_in) |=> !storing_out;
    endproperty
    a_store_blocked: assert property (p_store_blocked) else $error("store started blocked");

    property p_busy_ignore;
        (storing_out && (r.cnt != STORE_LAST)) || (recalling_out && (r.cnt != RECALL_LAST))
            |=> $stable(storing_out) && $stable(recalling_out);
    endproperty
    a_busy_ignore: assert property (p_busy_ignore) else $error("transfer interrupted");

endmodule

`default_nettype wire

// file: verilog/nv_store_recall_pkg.sv
// Constants and types shared by the store/recall control block
// How it works
// - Recall pin low, store pin high, no instruction running: recall, latches ignored.
// - Both pins high and software recall command: recall, latches ignored.
// - A store, by pin or command, needs write-enable and previous-recall latches set.
// - Pin requests are acted on only while no serial instruction runs.
// - Recall pin low floats the serial data output within the float time.
// - Serial data output floats within the select float time after chip select goes low.
// - A store completes within the store duration; host waits before write disable.
// - Reset clears both latches, so no store until both are set again.
// - No store starts while recall is low or chip select is low.
`default_nettype none

package nv_store_recall_pkg;

    // Clock
    localparam int CLK_PERIOD_NS = 5;

    // Array shape
    localparam int WORDS  = 16;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 4;
    localparam int CNT_W  = 20;

    // Timing figures as printed
    localparam int POWERUP_READ_DELAY_US       = 200;
    localparam int RECALL_PULSE_MIN_NS         = 500;
    localparam int RECALL_OUTPUT_FLOAT_TIME_NS = 500;
    localparam int STORE_PULSE_MIN_NS          = 200;
    localparam int SELECT_OUTPUT_FLOAT_TIME_NS = 1000;
    localparam int STORE_DURATION_MS           = 5;
    localparam int RECALL_CYCLE_NS             = 2000;

    // Cycle counts: longest times round down, least times round up
    localparam int STORE_DURATION_CYCLES =
        STORE_DURATION_MS * 1000000 / CLK_PERIOD_NS;
    localparam int RECALL_CYCLE_CYCLES =
        (RECALL_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECALL_FLOAT_CYCLES = RECALL_OUTPUT_FLOAT_TIME_NS / CLK_PERIOD_NS;
    localparam int SELECT_FLOAT_CYCLES = SELECT_OUTPUT_FLOAT_TIME_NS / CLK_PERIOD_NS;

    // Values after reset
    localparam logic WE_LATCH_RST = 1'b0;
    localparam logic PR_LATCH_RST = 1'b0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_RECALL,
        ST_STORE
    } xfer_state_e;

endpackage

`default_nettype wire

// file: verilog/nv_word_mem.sv
// Small word memory with one write port and a registered read port
`default_nettype none

module nv_word_mem
    import nv_store_recall_pkg::*;
#(
    parameter int DEPTH = WORDS,
    parameter int WIDTH = WORD_W,
    parameter int AW    = ADDR_W
)
(
    // Clock and reset
    input  wire logic             mclk_in,
    input  wire logic             rst_b_in,
    // Write port
    input  wire logic             wr_en_in,
    input  wire logic [AW-1:0]    wr_addr_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    // Read port
    input  wire logic [AW-1:0]    rd_addr_in,
    output logic      [WIDTH-1:0] rd_data_out
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge mclk_in)
    begin
        if (wr_en_in)
        begin
            mem[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            rd_data_out <= '0;
        end
        else
        begin
            rd_data_out <= mem[rd_addr_in];
        end
    end

endmodule

`default_nettype wire
